// ===== rtl/tsl_pkg.sv
/*
 * Shared types and constants of the torque and speed limiter.
 * Assumes torque figures in 0.1 % of rated torque and speed figures in
 * 0.01 r/min (or the command unit per second when that unit is chosen).
 */
package tsl_pkg;

    localparam int TRQ_W = 16;
    localparam int SPD_W = 32;

    // Unsigned torque setting, 16'h03e8 is rated torque or continuous thrust
    typedef logic [TRQ_W-1:0] tsl_trq_t;
    typedef logic signed [TRQ_W-1:0] tsl_strq_t;
    typedef logic [SPD_W-1:0] tsl_spd_t;
    typedef logic signed [SPD_W-1:0] tsl_sspd_t;

    typedef enum logic [1:0]
    {
        TSL_MODE_POS = 2'b00,
        TSL_MODE_VEL = 2'b01,
        TSL_MODE_TRQ = 2'b10,
        TSL_MODE_HOME = 2'b11
    } tsl_mode_e;

    localparam tsl_trq_t TRQ_ZERO = 16'h0000;
    localparam tsl_spd_t SPD_LIMIT_RST = 32'h000493e0;
    localparam tsl_spd_t SPD_EXT_RST = 32'h7fffffff;

    localparam int STS_TRQ_LIM_BIT = 13;
    localparam int STS_SPD_LIM_BIT = 4;
    localparam logic [15:0] STS_CLEAR = 16'h0000;

    localparam logic SEL_ENABLED = 1'b1;
    localparam logic REFLECT_ON = 1'b0;
    localparam logic DIR_REVERSED = 1'b1;
    localparam logic UNIT_CMD = 1'b1;

endpackage

// ===== rtl/tsl_lim_if.sv
/*
 * Effective limits handed from the limit calculation to the limiter core.
 * Assumes both ends run on the one clock of the limiter.
 */
`timescale 1ns/1ps
interface tsl_lim_if;
    import tsl_pkg::*;
    tsl_trq_t fwd_lim;
    tsl_trq_t rev_lim;
    tsl_spd_t spd_lim;
    logic all_zero;

    modport calc
    (
        output fwd_lim,
        output rev_lim,
        output spd_lim,
        output all_zero
    );
    modport apply
    (
        input fwd_lim,
        input rev_lim,
        input spd_lim,
        input all_zero
    );
endinterface

// ===== rtl/tsl_limit_calc.sv
/*
 * Source selection and minimum of the torque limits, and speed limit
 * storage and selection. Registered results go out through tsl_lim_if.
 * Assumes the motor maximum torque input never exceeds 16'h7fff.
 */
`timescale 1ns/1ps
module tsl_limit_calc
    import tsl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire tsl_trq_t fwd_torque_limit_setting,
    input wire tsl_trq_t rev_torque_limit_setting,
    input wire tsl_trq_t max_torque_limit1_setting,
    input wire tsl_trq_t fwd_net_value,
    input wire tsl_trq_t rev_net_value,
    input wire tsl_trq_t max_limit1_net_value,
    input wire logic fwd_net_map,
    input wire logic rev_net_map,
    input wire logic max_limit1_net_map,
    input wire tsl_trq_t max_torque_obj,
    input wire tsl_trq_t motor_max_torque,
    input wire logic max_torque_limit1_select,
    input wire logic torque_polarity_reflect,
    input wire logic travel_direction_select,
    input wire logic speed_limit_wr,
    input wire logic speed_limit_ext_wr,
    input wire tsl_spd_t speed_wr_data,
    input wire logic speed_unit_select,
    input wire logic vel_net_map,
    input wire tsl_spd_t vel_net_value,
    tsl_lim_if.calc lim
);

    function automatic tsl_trq_t min2(input tsl_trq_t a, input tsl_trq_t b);
        return (a < b) ? a : b;
    endfunction

    tsl_trq_t pos_obj, neg_obj, fwd_sel, rev_sel, ml1_sel, max_cap;
    tsl_spd_t speed_cap_r, speed_cap_extended_r, spd_sel;
    logic swap;

    always_comb
    begin
        pos_obj = fwd_net_map ? fwd_net_value : fwd_torque_limit_setting; // RULE_09
        neg_obj = rev_net_map ? rev_net_value : rev_torque_limit_setting; // RULE_09
        ml1_sel = max_limit1_net_map ? max_limit1_net_value : max_torque_limit1_setting;
        swap = (torque_polarity_reflect == REFLECT_ON) &&
               (travel_direction_select == DIR_REVERSED); // RULE_08
        fwd_sel = swap ? neg_obj : pos_obj; // RULE_08
        rev_sel = swap ? pos_obj : neg_obj; // RULE_08
        if (max_torque_limit1_select == SEL_ENABLED) // RULE_02
            max_cap = min2(min2(ml1_sel, max_torque_obj), motor_max_torque); // RULE_03
        else
            max_cap = motor_max_torque; // RULE_02
        spd_sel = vel_net_map ? vel_net_value : // RULE_16
                  (speed_unit_select == UNIT_CMD) ? speed_cap_extended_r : speed_cap_r; // RULE_14
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            speed_cap_r <= SPD_LIMIT_RST; // RULE_13
        else if (speed_limit_wr)
            speed_cap_r <= speed_wr_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            speed_cap_extended_r <= SPD_EXT_RST; // RULE_14
        else if (speed_limit_ext_wr)
            speed_cap_extended_r <= speed_wr_data;
    end

    // Zero torque limits are the safe value until the first sample after reset; the speed limit resets to SPD_LIMIT_RST
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lim.fwd_lim <= TRQ_ZERO;
            lim.rev_lim <= TRQ_ZERO;
            lim.spd_lim <= SPD_LIMIT_RST;
            lim.all_zero <= 1'b1;
        end
        else
        begin
            lim.fwd_lim <= min2(fwd_sel, max_cap); // RULE_17
            lim.rev_lim <= min2(rev_sel, max_cap); // RULE_17
            lim.spd_lim <= spd_sel;
            lim.all_zero <= (fwd_sel == TRQ_ZERO) && (rev_sel == TRQ_ZERO) &&
                            (ml1_sel == TRQ_ZERO); // RULE_04
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_MOTOR_MAX: assert property ( // RULE_03
        1'b1 |=> (lim.fwd_lim <= $past(motor_max_torque)) &&
                 (lim.rev_lim <= $past(motor_max_torque)))
        else $error("torque limit above motor maximum");

    AST_SEL_CAP: assert property ( // RULE_02
        (max_torque_limit1_select == SEL_ENABLED) |=>
            (lim.fwd_lim <= $past(max_torque_obj)) && (lim.rev_lim <= $past(ml1_sel)))
        else $error("maximum torque limit 1 not applied");

    AST_SWAP: assert property ( // RULE_08
        swap |=> (lim.fwd_lim <= $past(neg_obj)) && (lim.rev_lim <= $past(pos_obj)))
        else $error("direction limits not swapped");

    AST_NET_WINS: assert property ( // RULE_09
        fwd_net_map && !swap && (fwd_net_value <= max_cap) |=>
            lim.fwd_lim == $past(fwd_net_value))
        else $error("network forward limit not used");

    AST_SPD_UNIT: assert property ( // RULE_14
        (speed_unit_select == UNIT_CMD) && !vel_net_map |=>
            lim.spd_lim == $past(speed_cap_extended_r))
        else $error("extended speed limit not used");

    AST_VEL_NET: assert property ( // RULE_16
        vel_net_map |=> lim.spd_lim == $past(vel_net_value))
        else $error("network speed limit not used");

endmodule

// ===== rtl/tsl_torque_speed_limiter.sv
/*
 * Torque and speed limiter core: clamps the torque command to the
 * direction limits, cuts it at the speed limit in torque mode, and
 * reports the limiting-torque and limiting-speed flags.
 * Assumes all inputs are synchronous to clk and held once per control cycle.
 */
//
// Behaviour
// RULE_01: Torque is always capped by the forward and reverse torque limits.
// RULE_02: Selection 1 adds the limit-1 setting and max-torque object as cap, else motor max.
// RULE_03: No effective limit may exceed the motor's maximum torque.
// RULE_04: Forward, reverse and limit-1 all zero means zero torque out.
// RULE_05: Torque settings are in 0.1 percent, 16'h03e8 being rated torque.
// RULE_06: Forward limit governs positive torque (CCW power running, CW regeneration).
// RULE_07: Reverse limit governs negative torque (CW power running, CCW regeneration).
// RULE_08: Reflection enabled with reversed travel swaps the two limit objects.
// RULE_09: A network-mapped limit value replaces the tool-written setting.
// RULE_10: Limiting-torque output and status word 1 bit 13 show torque at a limit.
// RULE_11: The speed limit acts only in torque mode.
// RULE_12: Speed is limited only in the direction of the torque command.
// RULE_13: The speed limit comes from its setting, resetting to 3000.00.
// RULE_14: Command-unit speeds use the extended setting, resetting to 2147483647.
// RULE_15: Limiting-speed output and status word 2 bit 4 show speed at the limit.
// RULE_16: A cyclically mapped velocity limit replaces the tool-written one.
// RULE_17: Each direction's limit is the least of its applicable limits.
`timescale 1ns/1ps
module tsl_torque_speed_limiter
    import tsl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire tsl_strq_t torque_cmd_in,
    input wire tsl_strq_t motor_torque,
    input wire tsl_sspd_t motor_speed,
    input wire tsl_mode_e control_mode,
    input wire tsl_trq_t fwd_torque_limit_setting,
    input wire tsl_trq_t rev_torque_limit_setting,
    input wire tsl_trq_t max_torque_limit1_setting,
    input wire tsl_trq_t fwd_net_value,
    input wire tsl_trq_t rev_net_value,
    input wire tsl_trq_t max_limit1_net_value,
    input wire logic fwd_net_map,
    input wire logic rev_net_map,
    input wire logic max_limit1_net_map,
    input wire tsl_trq_t max_torque_obj,
    input wire tsl_trq_t motor_max_torque,
    input wire logic max_torque_limit1_select,
    input wire logic torque_polarity_reflect,
    input wire logic travel_direction_select,
    input wire logic speed_limit_wr,
    input wire logic speed_limit_ext_wr,
    input wire tsl_spd_t speed_wr_data,
    input wire logic speed_unit_select,
    input wire logic vel_net_map,
    input wire tsl_spd_t vel_net_value,
    output tsl_strq_t torque_cmd_out,
    output logic limiting_torque_out,
    output logic limiting_speed_out,
    output logic [15:0] status_do1,
    output logic [15:0] status_do2
);

    tsl_lim_if lim();

    tsl_limit_calc u_calc
    (
        .clk(clk),
        .rst(rst),
        .fwd_torque_limit_setting(fwd_torque_limit_setting),
        .rev_torque_limit_setting(rev_torque_limit_setting),
        .max_torque_limit1_setting(max_torque_limit1_setting),
        .fwd_net_value(fwd_net_value),
        .rev_net_value(rev_net_value),
        .max_limit1_net_value(max_limit1_net_value),
        .fwd_net_map(fwd_net_map),
        .rev_net_map(rev_net_map),
        .max_limit1_net_map(max_limit1_net_map),
        .max_torque_obj(max_torque_obj),
        .motor_max_torque(motor_max_torque),
        .max_torque_limit1_select(max_torque_limit1_select),
        .torque_polarity_reflect(torque_polarity_reflect),
        .travel_direction_select(travel_direction_select),
        .speed_limit_wr(speed_limit_wr),
        .speed_limit_ext_wr(speed_limit_ext_wr),
        .speed_wr_data(speed_wr_data),
        .speed_unit_select(speed_unit_select),
        .vel_net_map(vel_net_map),
        .vel_net_value(vel_net_value),
        .lim(lim.calc)
    );

    // One guard bit so that negating a limit and comparing signed never wraps
    logic signed [TRQ_W:0] cmd_x, fb_x, fwd_x, rev_x, neg_rev_x, cmd_clip;
    logic signed [SPD_W:0] spd_x, slim_x, neg_slim_x;
    tsl_strq_t fwd_q, rev_q, torque_cmd_nxt;
    logic fwd_hit, rev_hit, trq_hit, spd_fwd_hit, spd_rev_hit, spd_hit;
    logic in_trq_mode;

    assign cmd_x = {torque_cmd_in[TRQ_W-1], torque_cmd_in};
    assign fb_x = {motor_torque[TRQ_W-1], motor_torque};
    assign fwd_x = {1'b0, lim.fwd_lim}; // RULE_05
    assign rev_x = {1'b0, lim.rev_lim}; // RULE_05
    assign neg_rev_x = -rev_x;
    assign fwd_q = tsl_strq_t'(fwd_x[TRQ_W-1:0]);
    assign rev_q = tsl_strq_t'(neg_rev_x[TRQ_W-1:0]);

    assign spd_x = {motor_speed[SPD_W-1], motor_speed};
    assign slim_x = {1'b0, lim.spd_lim};
    assign neg_slim_x = -slim_x;

    // Torque clamp: positive torque against forward, negative against reverse
    always_comb
    begin
        if (cmd_x > fwd_x)
            cmd_clip = fwd_x; // RULE_06
        else if (cmd_x < neg_rev_x)
            cmd_clip = neg_rev_x; // RULE_07
        else
            cmd_clip = cmd_x; // RULE_01
    end

    // Motor torque at the active limit in either direction
    assign fwd_hit = fb_x >= fwd_x; // RULE_10
    assign rev_hit = fb_x <= neg_rev_x; // RULE_10
    assign trq_hit = fwd_hit || rev_hit; // RULE_10

    assign in_trq_mode = control_mode == TSL_MODE_TRQ; // RULE_11
    // Only the speed in the commanded direction is watched
    assign spd_fwd_hit = (cmd_x > 0) && (spd_x >= slim_x); // RULE_12
    assign spd_rev_hit = (cmd_x < 0) && (spd_x <= neg_slim_x); // RULE_12
    assign spd_hit = in_trq_mode && (spd_fwd_hit || spd_rev_hit); // RULE_11

    // Cutting torque at the speed limit is crude but needs no speed loop;
    // the motor coasts back under the limit and torque returns next cycle.
    always_comb
    begin
        if (lim.all_zero)
            torque_cmd_nxt = '0; // RULE_04
        else if (spd_hit)
            torque_cmd_nxt = '0; // RULE_15
        else
            torque_cmd_nxt = tsl_strq_t'(cmd_clip[TRQ_W-1:0]); // RULE_01
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            torque_cmd_out <= '0;
        else
            torque_cmd_out <= torque_cmd_nxt; // RULE_01
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            limiting_torque_out <= 1'b0;
            status_do1 <= STS_CLEAR;
        end
        else
        begin
            limiting_torque_out <= trq_hit; // RULE_10
            status_do1 <= STS_CLEAR;
            status_do1[STS_TRQ_LIM_BIT] <= trq_hit; // RULE_10
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            limiting_speed_out <= 1'b0;
            status_do2 <= STS_CLEAR;
        end
        else
        begin
            limiting_speed_out <= spd_hit; // RULE_15
            status_do2 <= STS_CLEAR;
            status_do2[STS_SPD_LIM_BIT] <= spd_hit; // RULE_15
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_clamped_to(logic cond, tsl_strq_t lim_val);
        cond |=> torque_cmd_out == $past(lim_val);
    endproperty

    AST_FWD_CAP: assert property ( // RULE_06
        p_clamped_to((cmd_x > fwd_x) && !lim.all_zero && !spd_hit, fwd_q))
        else $error("positive torque not clamped to forward limit");

    AST_REV_CAP: assert property ( // RULE_07
        p_clamped_to((cmd_x < neg_rev_x) && !lim.all_zero && !spd_hit, rev_q))
        else $error("negative torque not clamped to reverse limit");

    AST_PASS: assert property ( // RULE_01
        (cmd_x <= fwd_x) && (cmd_x >= neg_rev_x) && !lim.all_zero && !spd_hit
            |=> torque_cmd_out == $past(torque_cmd_in))
        else $error("torque inside limits was altered");

    AST_ZERO_ALL: assert property ( // RULE_04
        lim.all_zero [*2] |=> torque_cmd_out == '0)
        else $error("torque produced with all limits zero");

    AST_TRQ_FLAG: assert property ( // RULE_10
        trq_hit |=> limiting_torque_out && status_do1[STS_TRQ_LIM_BIT])
        else $error("limiting torque flag missing");

    AST_TRQ_FLAG_OFF: assert property ( // RULE_10
        !trq_hit |=> !limiting_torque_out && (status_do1 == STS_CLEAR))
        else $error("limiting torque flag without torque at limit");

    AST_SPD_MODE: assert property ( // RULE_11
        !in_trq_mode |=> !limiting_speed_out && !status_do2[STS_SPD_LIM_BIT])
        else $error("speed limit outside torque mode");

    AST_SPD_DIR: assert property ( // RULE_12
        (cmd_x > 0) && (spd_x < 0) |=> !limiting_speed_out)
        else $error("speed limited against torque direction");

    AST_SPD_DIR_REV: assert property ( // RULE_12
        (cmd_x < 0) && (spd_x > 0) |=> !limiting_speed_out)
        else $error("reverse command limited by forward speed");

    AST_SPD_FLAG: assert property ( // RULE_15
        spd_hit |=> limiting_speed_out && status_do2[STS_SPD_LIM_BIT] && (torque_cmd_out == '0))
        else $error("speed limit not applied or not flagged");

    COV_TRQ_FLAG: cover property (trq_hit ##1 limiting_torque_out);
    COV_SPD_FLAG: cover property (in_trq_mode && spd_hit ##1 limiting_speed_out);
    COV_REV_CLIP: cover property ((cmd_x < neg_rev_x) ##1 (torque_cmd_out < 0));
    COV_ZERO: cover property (lim.all_zero && (cmd_x != 0) ##1 (torque_cmd_out == '0));
    COV_SWAP: cover property (
        (torque_polarity_reflect == REFLECT_ON) && (travel_direction_select == DIR_REVERSED)
        ##2 (torque_cmd_out != '0));

endmodule

// ===== test/tsl_motor_model.sv
/*
 * Behavioural servo motor behind the limiter: torque follows the limited
 * command one cycle late, speed is whatever the bench sets.
 * Assumes one clock shared with the limiter and a synchronous reset.
 */
`timescale 1ns/1ps
module tsl_motor_model
    import tsl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire tsl_strq_t drive_torque,
    input wire tsl_sspd_t speed_set,
    output tsl_strq_t motor_torque,
    output tsl_sspd_t motor_speed
);
    // One cycle of lag stands in for the current loop
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            motor_torque <= '0;
            motor_speed <= '0;
        end
        else
        begin
            motor_torque <= drive_torque;
            motor_speed <= speed_set;
        end
    end
endmodule

// ===== test/tb_torque_and_speed_limiter.sv
/*
 * Self-checking bench of the torque and speed limiter with a motor model.
 * Assumes settings reach the output two edges after a change; every check
 * waits four edges so the motor feedback has settled as well.
 */
`timescale 1ns/1ps
module tb_torque_and_speed_limiter;
    import tsl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    tsl_strq_t torque_cmd_in = '0;
    tsl_strq_t motor_torque;
    tsl_sspd_t motor_speed;
    tsl_sspd_t speed_set = '0;
    tsl_mode_e control_mode = TSL_MODE_POS;
    tsl_trq_t fwd_set = '0, rev_set = '0, lim1_set = '0;
    tsl_trq_t fwd_net = '0, rev_net = '0, lim1_net = '0;
    logic fwd_map = 1'b0, rev_map = 1'b0, lim1_map = 1'b0;
    tsl_trq_t max_obj = 16'h7fff, motor_max = 16'h0bb8;
    logic lim1_sel = 1'b0, reflect = 1'b1, dir_sel = 1'b0;
    logic spd_wr = 1'b0, spd_ext_wr = 1'b0, unit_sel = 1'b0, vel_map = 1'b0;
    tsl_spd_t spd_data = '0, vel_net = '0;
    tsl_strq_t torque_cmd_out;
    logic limiting_torque_out, limiting_speed_out;
    logic [15:0] status_do1, status_do2;
    int n_errors = 0;
    int tests_run = 0;

    tsl_torque_speed_limiter i_tsl_torque_speed_limiter (.clk(clk), .rst(rst),
        .torque_cmd_in(torque_cmd_in), .motor_torque(motor_torque),
        .motor_speed(motor_speed), .control_mode(control_mode),
        .fwd_torque_limit_setting(fwd_set), .rev_torque_limit_setting(rev_set),
        .max_torque_limit1_setting(lim1_set), .fwd_net_value(fwd_net),
        .rev_net_value(rev_net), .max_limit1_net_value(lim1_net),
        .fwd_net_map(fwd_map), .rev_net_map(rev_map), .max_limit1_net_map(lim1_map),
        .max_torque_obj(max_obj), .motor_max_torque(motor_max),
        .max_torque_limit1_select(lim1_sel), .torque_polarity_reflect(reflect),
        .travel_direction_select(dir_sel), .speed_limit_wr(spd_wr),
        .speed_limit_ext_wr(spd_ext_wr), .speed_wr_data(spd_data),
        .speed_unit_select(unit_sel), .vel_net_map(vel_map), .vel_net_value(vel_net),
        .torque_cmd_out(torque_cmd_out), .limiting_torque_out(limiting_torque_out),
        .limiting_speed_out(limiting_speed_out), .status_do1(status_do1),
        .status_do2(status_do2));

    tsl_motor_model i_tsl_motor_model (.clk(clk), .rst(rst),
        .drive_torque(torque_cmd_out), .speed_set(speed_set),
        .motor_torque(motor_torque), .motor_speed(motor_speed));

    initial
    begin
        forever #20 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic drive(input tsl_strq_t c);
        torque_cmd_in = c;
        cyc(4);
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr_spd(input logic ext, input tsl_spd_t d);
        spd_data = d;
        spd_wr = ~ext;
        spd_ext_wr = ext;
        cyc(1);
        spd_wr = 1'b0;
        spd_ext_wr = 1'b0;
    endtask

    task automatic t_reset;
        chk(torque_cmd_out, 16'h0000, "reset torque");
        chk({status_do1, status_do2}, 32'h00000000, "reset status");
        rst = 1'b0;
        drive(16'sh01f4);
        chk(torque_cmd_out, 16'h0000, "all zero limits");
        $display("test reset done");
    endtask

    task automatic t_clip;
        fwd_set = 16'h03e8;
        rev_set = 16'h0320;
        drive(16'sh07d0);
        chk(torque_cmd_out, 16'h03e8, "forward clip");
        chk(limiting_torque_out, 1'b1, "torque flag");
        chk(status_do1, 16'h2000, "status word 1");
        drive(-16'sh07d0);
        chk(torque_cmd_out, -16'sh0320, "reverse clip");
        chk(limiting_torque_out, 1'b1, "reverse torque flag");
        chk(status_do1, 16'h2000, "status word 1 reverse");
        drive(16'sh01f4);
        chk(torque_cmd_out, 16'h01f4, "below limit");
        chk(limiting_torque_out, 1'b0, "torque flag off");
        $display("test clip done");
    endtask

    task automatic t_cap;
        lim1_sel = 1'b1;
        lim1_set = 16'h0258;
        max_obj = 16'h02bc;
        drive(16'sh07d0);
        chk(torque_cmd_out, 16'h0258, "limit-1 cap");
        max_obj = 16'h01f4;
        drive(16'sh07d0);
        chk(torque_cmd_out, 16'h01f4, "max object cap");
        lim1_sel = 1'b0;
        motor_max = 16'h0384;
        drive(16'sh07d0);
        chk(torque_cmd_out, 16'h0384, "motor max cap");
        motor_max = 16'h0bb8;
        max_obj = 16'h7fff;
        $display("test cap done");
    endtask

    task automatic t_swap;
        for (int i = 0; i < 4; i++)
        begin
            reflect = i[1];
            dir_sel = i[0];
            drive(16'sh07d0);
            chk(torque_cmd_out, (i == 1) ? 16'h0320 : 16'h03e8, "swap table");
        end
        reflect = 1'b1;
        dir_sel = 1'b0;
        $display("test swap done");
    endtask

    task automatic t_net;
        fwd_net = 16'h012c;
        fwd_map = 1'b1;
        drive(16'sh07d0);
        chk(torque_cmd_out, 16'h012c, "forward object");
        rev_net = 16'h00c8;
        rev_map = 1'b1;
        drive(-16'sh07d0);
        chk(torque_cmd_out, -16'sh00c8, "reverse object");
        lim1_sel = 1'b1;
        lim1_net = 16'h0064;
        lim1_map = 1'b1;
        drive(16'sh07d0);
        chk(torque_cmd_out, 16'h0064, "limit-1 object");
        {fwd_map, rev_map, lim1_map, lim1_sel} = 4'h0;
        $display("test net done");
    endtask

    task automatic t_speed;
        control_mode = TSL_MODE_TRQ;
        speed_set = 32'sh000493e0;
        drive(16'sh01f4);
        chk(torque_cmd_out, 16'h0000, "default speed limit");
        chk(limiting_speed_out, 1'b1, "speed flag");
        chk(status_do2, 16'h0010, "status word 2");
        speed_set = 32'sh000493df;
        drive(16'sh01f4);
        chk({torque_cmd_out, 15'h0000, limiting_speed_out}, 32'h01f40000, "under");
        speed_set = 32'sh000493e0;
        drive(-16'sh01f4);
        chk(torque_cmd_out, -16'sh01f4, "opposite direction");
        speed_set = -32'sh000493e0;
        drive(-16'sh01f4);
        chk(torque_cmd_out, 16'h0000, "reverse speed limit");
        chk(limiting_speed_out, 1'b1, "reverse speed flag");
        speed_set = 32'sh00061a80;
        for (int m = 0; m < 4; m++)
        begin
            if (m == 2)
                continue;
            control_mode = tsl_mode_e'(m);
            drive(16'sh01f4);
            chk(torque_cmd_out, 16'h01f4, "other mode");
        end
        control_mode = TSL_MODE_TRQ;
        wr_spd(1'b0, 32'h000003e8);
        speed_set = 32'sh000003e8;
        drive(16'sh01f4);
        chk(torque_cmd_out, 16'h0000, "written limit");
        unit_sel = 1'b1;
        speed_set = 32'sh00061a80;
        drive(16'sh01f4);
        chk(torque_cmd_out, 16'h01f4, "extended default");
        wr_spd(1'b1, 32'h000007d0);
        speed_set = 32'sh000007d0;
        drive(16'sh01f4);
        chk(torque_cmd_out, 16'h0000, "extended written");
        vel_net = 32'h00000fa0;
        vel_map = 1'b1;
        drive(16'sh01f4);
        chk(torque_cmd_out, 16'h01f4, "cyclic velocity limit");
        $display("test speed done");
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #(40 * 5000);
        n_errors++;
        $display("BAD %0t run did not finish", $time);
        close_out();
    end

    initial
    begin
        cyc(8);
        t_reset();
        t_clip();
        t_cap();
        t_swap();
        t_net();
        t_speed();
        close_out();
    end
endmodule
